// [pkg/ccm_map.vh]
`ifndef CCM_MAP_VH
`define CCM_MAP_VH
// register word indices (printed offsets are not all multiples of four,
// so each printed offset is an index and the byte address is four times it)
`define CCM_IDX_CTRL 8'h0c
`define CCM_IDX_COLL 8'h0e
`define CCM_IDX_MODE 8'h11
`define CCM_IDX_IRQ_STAT 8'h20
`define CCM_IDX_IRQ_MASK 8'h21
`define CCM_IDX_STATUS 8'h22
`define CCM_ADDR_W 10
// control register fields
`define CCM_CTRL_HALT 7
`define CCM_CTRL_GO 6
`define CCM_CTRL_IDCOPY 5
`define CCM_CTRL_RESET 8'h00
// collision fixed pattern
`define CCM_COLL_FIXED 3'h5
// mode register fields
`define CCM_MODE_RESET 8'h3b
`define CCM_MODE_ORDER 7
`define CCM_MODE_SYNC 6
`define CCM_MODE_RSV3 3
`define CCM_MODE_DETOFF 2
// sync byte
`define CCM_SYNC_BYTE 8'hf0
// identifier length in bytes
`define CCM_ID_LEN 4'ha
`define CCM_ID_LAST 4'h9
// interrupt status bits
`define CCM_IRQ_SIGIN 0
`define CCM_IRQ_IDDONE 1
`define CCM_IRQ_TMR 2
`define CCM_IRQ_W 3
`endif

// [rtl/ccm_regs.v]
// Operation
// - writing 1 to the halt strobe stops the timer; it reads back as 0
// - writing 1 to the go strobe starts the timer; it reads back as 0
// - writing 1 to the copy bit pushes the ten identifier bytes to queue
// - the copy bit clears itself when the last byte has been pushed
// - bits 2 to 0 of control report valid bits of last received byte
// - zero in that field means the whole last byte is valid
// - collision register top three bits read as 1, 0, 1
// - order bit 1 makes the checksum unit run high bit first, reversed
// - during radio traffic the order bit is ignored
// - sync bit 1 keeps the receiver off until byte f0 is seen
// - sync bit 1 makes the transmitter send f0 before frame data
// - mode register resets to 3b, all bits read and write
// - mode bit 3 going from 1 to 0 raises the signal-in event
// - detector disable bit 1 switches the mode detector off
// - mode detector runs only during the anticollision command
// - control register sits at 0c and resets to 00
`timescale 1ns/1ps
`include "ccm_map.vh"
module ccm_regs (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`CCM_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // core status inputs
  input wire [2:0] RX_FINAL_BIT_COUNT,
  input wire [4:0] COLL_POS_RAW,
  input wire RF_ACTIVE,
  input wire AUTO_ANTICOLLISION_CMD,
  input wire [7:0] RX_BYTE,
  input wire RX_BYTE_VALID,
  input wire RX_FRAME_END,
  input wire [7:0] CARD_IDENTIFIER_BYTE,
  input wire QUEUE_READY,
  // timer control
  output reg TIMER_HALT_STROBE,
  output reg TIMER_GO_STROBE,
  // identifier copy to queue
  output reg [3:0] CARD_IDENTIFIER_INDEX,
  output reg [7:0] QUEUE_WDATA,
  output reg QUEUE_WRITE,
  // mode controls
  output reg CRC_HIGH_BIT_ORDER,
  output reg SYNC_BYTE_ENABLE,
  output reg SYNC_SEND_FIRST,
  output reg RX_ENABLE,
  output reg MODE_DETECTOR_ON,
  output reg SIGNAL_IN_ACTIVE_EVENT,
  // interrupt
  output reg IRQ
);

  // copy machine states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_COPY = 2'b10;

  reg [7:0] mode_reg;
  reg [7:0] mode_next;
  reg id_copy_to_queue_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] idx_reg;
  reg [3:0] idx_next;
  reg [`CCM_IRQ_W-1:0] stat_reg;
  reg [`CCM_IRQ_W-1:0] mask_reg;
  reg rx_hunt_reg;
  reg [31:0] rdata;
  reg decode_ok;
  reg [`CCM_IRQ_W-1:0] ev;
  wire acc = PSEL & PENABLE & PREADY;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  wire [7:0] idx = PADDR[`CCM_ADDR_W-1:2];
  wire wr_ctrl = wr & (idx == `CCM_IDX_CTRL);
  wire wr_mode = wr & (idx == `CCM_IDX_MODE);
  wire rd_stat = rd & (idx == `CCM_IDX_IRQ_STAT);
  wire copy_last = (state_reg == ST_COPY) & QUEUE_WRITE & QUEUE_READY &
    (idx_reg == `CCM_ID_LAST);

  // read mux; strobes always read back as zero
  always @* begin
    rdata = 32'h0000_0000;
    decode_ok = 1'b1;
    case (idx)
      `CCM_IDX_CTRL: begin
        // count passes through raw; 0 already means full byte
        rdata[7:0] = {2'b00, id_copy_to_queue_reg, 2'b00,
          RX_FINAL_BIT_COUNT};
      end
      `CCM_IDX_COLL: begin
        rdata[7:0] = {`CCM_COLL_FIXED, COLL_POS_RAW};
      end
      `CCM_IDX_MODE: begin
        rdata[7:0] = mode_reg;
      end
      `CCM_IDX_IRQ_STAT: begin
        rdata[`CCM_IRQ_W-1:0] = stat_reg;
      end
      `CCM_IDX_IRQ_MASK: begin
        rdata[`CCM_IRQ_W-1:0] = mask_reg;
      end
      `CCM_IDX_STATUS: begin
        rdata[3:0] = {rx_hunt_reg, MODE_DETECTOR_ON, state_reg};
      end
      default: begin
        decode_ok = 1'b0;
      end
    endcase
  end

  // apb answer: one wait state, error on unmapped address
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~decode_ok;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        PRDATA <= rdata;
      end
    end
  end

  // mode register next value
  always @* begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = PWDATA[7:0];
    end
  end

  // copy machine next state
  always @* begin
    state_next = state_reg;
    idx_next = idx_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_ctrl & PWDATA[`CCM_CTRL_IDCOPY]) begin
          state_next = ST_COPY;
          idx_next = 4'h0;
        end
      end
      ST_COPY: begin
        if (QUEUE_WRITE & QUEUE_READY) begin
          if (copy_last) begin
            state_next = ST_IDLE;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // events: mode bit 3 falling, copy done, any timer strobe
  always @* begin
    ev = {`CCM_IRQ_W{1'b0}};
    ev[`CCM_IRQ_SIGIN] = mode_reg[`CCM_MODE_RSV3] &
      ~mode_next[`CCM_MODE_RSV3];
    ev[`CCM_IRQ_IDDONE] = copy_last;
    ev[`CCM_IRQ_TMR] = wr_ctrl & (PWDATA[`CCM_CTRL_HALT] |
      PWDATA[`CCM_CTRL_GO]);
  end

  // registers and outputs
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_reg <= `CCM_MODE_RESET;
      id_copy_to_queue_reg <= 1'b0;
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      stat_reg <= {`CCM_IRQ_W{1'b0}};
      mask_reg <= {`CCM_IRQ_W{1'b0}};
      rx_hunt_reg <= 1'b0;
      TIMER_HALT_STROBE <= 1'b0;
      TIMER_GO_STROBE <= 1'b0;
      CARD_IDENTIFIER_INDEX <= 4'h0;
      QUEUE_WDATA <= 8'h00;
      QUEUE_WRITE <= 1'b0;
      CRC_HIGH_BIT_ORDER <= 1'b0;
      SYNC_BYTE_ENABLE <= 1'b0;
      SYNC_SEND_FIRST <= 1'b0;
      RX_ENABLE <= 1'b1;
      MODE_DETECTOR_ON <= 1'b0;
      SIGNAL_IN_ACTIVE_EVENT <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      state_reg <= state_next;
      idx_reg <= idx_next;
      id_copy_to_queue_reg <= (state_next == ST_COPY);
      // halt wins if both strobes written together
      TIMER_HALT_STROBE <= wr_ctrl & PWDATA[`CCM_CTRL_HALT];
      TIMER_GO_STROBE <= wr_ctrl & PWDATA[`CCM_CTRL_GO] &
        ~PWDATA[`CCM_CTRL_HALT];
      // queue push stands while the consumer stalls; the byte is fetched
      // one cycle ahead of the push so data always matches the index
      CARD_IDENTIFIER_INDEX <= idx_next;
      QUEUE_WRITE <= (QUEUE_WRITE & ~QUEUE_READY) |
        ((state_reg == ST_COPY) & ~QUEUE_WRITE);
      QUEUE_WDATA <= CARD_IDENTIFIER_BYTE;
      // radio traffic uses its protocol order regardless of the bit
      CRC_HIGH_BIT_ORDER <= mode_next[`CCM_MODE_ORDER] &
        ~RF_ACTIVE;
      SYNC_BYTE_ENABLE <= mode_next[`CCM_MODE_SYNC];
      SYNC_SEND_FIRST <= mode_next[`CCM_MODE_SYNC];
      // hunt for f0 after each frame end while sync is on
      if (!mode_next[`CCM_MODE_SYNC]) begin
        rx_hunt_reg <= 1'b0;
      end else if (RX_BYTE_VALID && RX_BYTE == `CCM_SYNC_BYTE) begin
        rx_hunt_reg <= 1'b0;
      end else if (RX_FRAME_END || !mode_reg[`CCM_MODE_SYNC]) begin
        rx_hunt_reg <= 1'b1;
      end
      RX_ENABLE <= ~rx_hunt_reg | ~mode_next[`CCM_MODE_SYNC];
      MODE_DETECTOR_ON <= AUTO_ANTICOLLISION_CMD &
        ~mode_next[`CCM_MODE_DETOFF];
      SIGNAL_IN_ACTIVE_EVENT <= ev[`CCM_IRQ_SIGIN];
      if (wr & (idx == `CCM_IDX_IRQ_MASK)) begin
        mask_reg <= PWDATA[`CCM_IRQ_W-1:0];
      end
      // new events win over the read clear
      stat_reg <= (rd_stat ? {`CCM_IRQ_W{1'b0}} : stat_reg) | ev;
      IRQ <= |(((rd_stat ? {`CCM_IRQ_W{1'b0}} : stat_reg) | ev) &
        mask_reg);
    end
  end

endmodule

// [test/ccm_regs_sva.sv]
`timescale 1ns/1ps
`include "ccm_map.vh"
module ccm_regs_sva (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`CCM_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  // core side
  input wire TIMER_HALT_STROBE,
  input wire TIMER_GO_STROBE,
  input wire QUEUE_WRITE,
  input wire QUEUE_READY,
  input wire [3:0] CARD_IDENTIFIER_INDEX,
  input wire AUTO_ANTICOLLISION_CMD,
  input wire MODE_DETECTOR_ON,
  input wire SIGNAL_IN_ACTIVE_EVENT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // completed writes, seen at the ready edge
  wire wr = PSEL && PENABLE && PREADY && PWRITE;
  wire ctl_wr = wr && PADDR == {`CCM_IDX_CTRL, 2'b00};
  wire rsv_clr = wr && PADDR == {`CCM_IDX_MODE, 2'b00} && !PWDATA[3];
  sequence s_halt_req;
    ctl_wr && PWDATA[7];
  endsequence
  sequence s_go_req;
    ctl_wr && PWDATA[7:6] == 2'b01;
  endsequence
  a_halt_pulse: assert property (s_halt_req |-> ##[1:2] TIMER_HALT_STROBE)
    else $error("halt strobe missing");
  a_go_pulse: assert property (s_go_req |-> ##[1:2] TIMER_GO_STROBE)
    else $error("go strobe missing");
  a_halt_wins: assert property (!(TIMER_HALT_STROBE && TIMER_GO_STROBE))
    else $error("both strobes high");
  a_go_single: assert property ($rose(TIMER_GO_STROBE) |=> !TIMER_GO_STROBE)
    else $error("go strobe too long");
  a_copy_hold: assert property (QUEUE_WRITE && !QUEUE_READY |=>
    QUEUE_WRITE && $stable(CARD_IDENTIFIER_INDEX))
    else $error("copy dropped while stalled");
  a_copy_stop: assert property (QUEUE_WRITE && QUEUE_READY &&
    CARD_IDENTIFIER_INDEX == `CCM_ID_LAST |=> !QUEUE_WRITE)
    else $error("copy ran past last byte");
  a_det_gate: assert property (MODE_DETECTOR_ON |->
    $past(AUTO_ANTICOLLISION_CMD))
    else $error("detector on outside command");
  a_sig_cause: assert property (SIGNAL_IN_ACTIVE_EVENT |->
    $past(rsv_clr) || $past(rsv_clr, 2))
    else $error("signal-in event without cause");
endmodule
bind ccm_regs ccm_regs_sva u_sva (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PREADY, .TIMER_HALT_STROBE, .TIMER_GO_STROBE,
  .QUEUE_WRITE, .QUEUE_READY, .CARD_IDENTIFIER_INDEX,
  .AUTO_ANTICOLLISION_CMD, .MODE_DETECTOR_ON, .SIGNAL_IN_ACTIVE_EVENT);

// [test/ccm_queue_model.sv]
`timescale 1ns/1ps
module ccm_queue_model (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // identifier store and queue
  input wire [3:0] index,
  output wire [7:0] id_byte,
  input wire [7:0] wdata,
  input wire write,
  input wire stall,
  output wire ready,
  output reg [4:0] taken,
  output reg bad
);
  reg ph;
  // byte value follows its position so order slips show
  assign id_byte = 8'ha0 + {4'h0, index};
  // stalls every other cycle to force held writes
  assign ready = !(stall && ph);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph <= 1'b0;
      taken <= 5'h00;
      bad <= 1'b0;
    end else begin
      ph <= ~ph;
      if (write && ready) begin
        taken <= taken + 5'h01;
        if (wdata !== 8'ha0 + {3'h0, taken}) bad <= 1'b1;
      end
    end
  end
endmodule

// [test/test_contactless_control_mode_regs.sv]
`timescale 1ns/1ps
`include "ccm_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_contactless_control_mode_regs;
  reg clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, rf = 1'b0, auto = 1'b0, rxv = 1'b0, stall = 1'b0;
  reg fe = 1'b0;
  wire sye;
  reg [9:0] paddr = 10'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [2:0] rx_cnt = 3'h0;
  reg [7:0] rxb = 8'h00;
  reg err;
  wire [31:0] prdata;
  wire pready, pslverr, halt, go, qw, crc, syf, rx_en, det, sig, irq, qr, bad;
  wire [3:0] idx;
  wire [7:0] idb, qd;
  wire [4:0] taken;
  integer errors = 0, compares = 0, halt_n = 0, go_n = 0, sig_n = 0, n;
  localparam [9:0] a_ctl = {`CCM_IDX_CTRL, 2'b00};
  localparam [9:0] a_mode = {`CCM_IDX_MODE, 2'b00};
  always #50 clk = ~clk;
  // pulse counters, since strobes stand one cycle only
  always @(posedge clk) begin
    if (halt) halt_n <= halt_n + 1;
    if (go) go_n <= go_n + 1;
    if (sig) sig_n <= sig_n + 1;
  end
  ccm_regs u_dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_FINAL_BIT_COUNT(rx_cnt), .COLL_POS_RAW(5'h1f), .RF_ACTIVE(rf),
    .AUTO_ANTICOLLISION_CMD(auto), .RX_BYTE(rxb), .RX_BYTE_VALID(rxv),
    .RX_FRAME_END(fe), .CARD_IDENTIFIER_BYTE(idb), .QUEUE_READY(qr),
    .TIMER_HALT_STROBE(halt), .TIMER_GO_STROBE(go),
    .CARD_IDENTIFIER_INDEX(idx), .QUEUE_WDATA(qd), .QUEUE_WRITE(qw),
    .CRC_HIGH_BIT_ORDER(crc), .SYNC_BYTE_ENABLE(sye), .SYNC_SEND_FIRST(syf),
    .RX_ENABLE(rx_en), .MODE_DETECTOR_ON(det),
    .SIGNAL_IN_ACTIVE_EVENT(sig), .IRQ(irq));
  ccm_queue_model u_q (.clk(clk), .reset_n(reset_n), .index(idx),
    .id_byte(idb), .wdata(qd), .write(qw), .stall(stall), .ready(qr),
    .taken(taken), .bad(bad));
  task conclude;
    begin
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task apb(input w, input [9:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge clk); k = k + 1; end while (!pready && k < 20);
      if (pready !== 1'b1) begin errors++; conclude; end
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  // let outputs of the last edges settle before looking
  task tick(input integer c);
    begin repeat (c) @(posedge clk); #1; end
  endtask
  task t_reset;
    begin
      apb(0, a_mode, 0); `CHK(rd, 32'h3b)
      apb(0, a_ctl, 0); `CHK(rd, 32'h0)
      apb(1, 10'h3fc, 32'hff); `CHK(err, 1'b1)
    end
  endtask
  task t_timer;
    begin
      apb(1, a_ctl, 32'hc0); tick(3);
      `CHK(halt_n, 1) `CHK(go_n, 0)
      apb(1, a_ctl, 32'h40); tick(3); `CHK(go_n, 1)
      apb(0, a_ctl, 0); `CHK(rd[7:6], 2'b00)
    end
  endtask
  task t_copy;
    begin
      `CHK(irq, 1'b0)
      apb(1, {`CCM_IDX_IRQ_MASK, 2'b00}, 32'h2);
      @(posedge clk) stall <= 1'b1;
      apb(1, a_ctl, 32'h20); apb(0, a_ctl, 0); `CHK(rd[5], 1'b1)
      n = 0;
      while (rd[5] === 1'b1 && n < 40) begin apb(0, a_ctl, 0); n++; end
      tick(2); `CHK(taken, 5'h0a) `CHK(bad, 1'b0) `CHK(irq, 1'b1)
      apb(0, {`CCM_IDX_IRQ_STAT, 2'b00}, 0); `CHK(rd[1], 1'b1)
      tick(2); `CHK(irq, 1'b0)
    end
  endtask
  task t_bits;
    begin
      @(posedge clk) rx_cnt <= 3'h5;
      apb(0, a_ctl, 0); `CHK(rd[2:0], 3'h5)
      @(posedge clk) rx_cnt <= 3'h0;
      apb(0, a_ctl, 0); `CHK(rd[2:0], 3'h0)
      apb(0, {`CCM_IDX_COLL, 2'b00}, 0); `CHK(rd[7:5], 3'h5)
    end
  endtask
  task t_mode;
    begin
      apb(1, a_mode, 32'h33); tick(3); `CHK(sig_n, 1)
      apb(0, a_mode, 0); `CHK(rd, 32'h33)
      apb(1, a_mode, 32'h4b); tick(2);
      `CHK(rx_en, 1'b0) `CHK(syf, 1'b1)
      `CHK(sye, 1'b1)
      @(posedge clk) begin rxb <= 8'h55; rxv <= 1'b1; end
      @(posedge clk) rxv <= 1'b0;
      tick(2); `CHK(rx_en, 1'b0)
      @(posedge clk) begin rxb <= `CCM_SYNC_BYTE; rxv <= 1'b1; end
      @(posedge clk) rxv <= 1'b0;
      tick(2); `CHK(rx_en, 1'b1)
      @(posedge clk) fe <= 1'b1;
      @(posedge clk) fe <= 1'b0;
      tick(2); `CHK(rx_en, 1'b0)
      apb(1, a_mode, 32'h8b); tick(2); `CHK(crc, 1'b1)
      @(posedge clk) rf <= 1'b1;
      tick(2); `CHK(crc, 1'b0)
      @(posedge clk) begin rf <= 1'b0; auto <= 1'b1; end
      apb(1, a_mode, 32'h3b); tick(2); `CHK(det, 1'b1)
      apb(1, a_mode, 32'h3f); tick(2); `CHK(det, 1'b0)
      @(posedge clk) auto <= 1'b0;
      apb(1, a_mode, 32'h3b); tick(2); `CHK(det, 1'b0)
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_timer;
    t_copy;
    t_bits;
    t_mode;
    conclude;
  end
endmodule
